// ---- aftpc_pkg.sv ----
package aftpc_pkg;
    // Register offsets in the serial-port space
    localparam logic [9:0] REG_FILT_TUNE_HP = 10'h02B;
    localparam logic [9:0] REG_FILT_ROUTE = 10'h109;
    localparam logic [9:0] REG_LPF_SCALE = 10'h00F;
    localparam logic [9:0] REG_LNA_BIAS = 10'h012;
    localparam logic [9:0] REG_CLK_CTRL = 10'h100;
    localparam logic [9:0] REG_STATUS = 10'h101;
    // Field positions
    localparam int TUNE_START_BIT = 6;
    localparam int ROUTE_EN_BIT = 4;
    localparam int DCS_EN_BIT = 0;
    // Reset values
    localparam logic [7:0] RST_FILT_TUNE_HP = 8'h00;
    localparam logic [7:0] RST_FILT_ROUTE = 8'h00;
    localparam logic [7:0] RST_LPF_SCALE = 8'h00;
    localparam logic [7:0] RST_LNA_BIAS = 8'h03;
    localparam logic [7:0] RST_CLK_CTRL = 8'h01;
    // Cycle counts, clock rate, wake time in microseconds and sample width
    localparam int TUNE_CYCLES = 512;
    localparam int DLL_LOCK_CYCLES = 8;
    localparam int CLK_MHZ = 25;
    localparam int POWERDOWN_PIN_WAKE_US = 375;
    localparam int POWERDOWN_PIN_WAKE_CYCLES = POWERDOWN_PIN_WAKE_US * CLK_MHZ;
    localparam int STANDBY_PIN_WAKE_CYCLES = 50;
    localparam int PIPE_LATENCY = 8;
    localparam int SAMPLE_W = 14;

    typedef enum logic [1:0] {
        AFTPC_RUN = 2'b00,
        AFTPC_WAKE = 2'b01,
        AFTPC_STANDBY_PIN = 2'b11,
        AFTPC_POWERDOWN_PIN = 2'b10
    } aftpc_pwr_t;

    // Serial-port register access strobe bundle
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [9:0] addr;
        logic [7:0] wdata;
    } aftpc_regreq_t;
endpackage

// ---- aftpc_adc_pipe.sv ----
module aftpc_adc_pipe
    import aftpc_pkg::*;
#(
    parameter int WIDTH = SAMPLE_W,
    parameter int DEPTH = PIPE_LATENCY
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] rawSample,
    input wire logic [WIDTH-1:0] corrTerm,
    output logic [WIDTH-1:0] result
);
    logic [WIDTH-1:0] stage_ff [DEPTH];

    // Stage 0 corrects and takes a new sample on every clock with clkEn high; later stages carry older ones
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_stage
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    stage_ff[gi] <= '0;
                end else if (clkEn) begin
                    if (gi == 0) begin
                        stage_ff[gi] <= rawSample + corrTerm;
                    end else begin
                        stage_ff[gi] <= stage_ff[gi-1];
                    end
                end
            end
        end
    endgenerate

    assign result = stage_ff[DEPTH-1];
endmodule

// ---- aftpc_serializer.sv ----
module aftpc_serializer
    import aftpc_pkg::*;
#(
    parameter int WIDTH = SAMPLE_W
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] word,
    output logic serBit,
    output logic frameMark
);
    logic [WIDTH-1:0] shift_ff;
    logic [$clog2(WIDTH)-1:0] cnt_ff;
    logic serBit_ff;
    logic frame_ff;
    wire lastBit = (cnt_ff == ($clog2(WIDTH))'(WIDTH - 1));

    // Aligned word loaded at frame start, then shifted MSB first
    always_ff @(posedge core_clk) begin
        if (srst) begin
            shift_ff <= '0;
            cnt_ff <= '0;
            serBit_ff <= 1'b0;
            frame_ff <= 1'b0;
        end else if (clkEn) begin
            cnt_ff <= lastBit ? '0 : cnt_ff + 1'b1;
            shift_ff <= lastBit ? word : {shift_ff[WIDTH-2:0], 1'b0};
            serBit_ff <= shift_ff[WIDTH-1];
            frame_ff <= lastBit;
        end
    end

    assign serBit = serBit_ff;
    assign frameMark = frame_ff;
endmodule

// ---- aftpc_core.sv ----
module aftpc_core
    import aftpc_pkg::*;
#(
    parameter int NCH = 8,
    parameter int WAKE_MAX = POWERDOWN_PIN_WAKE_CYCLES
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire aftpc_regreq_t regReq,
    output logic [7:0] regRdata,
    input wire logic powerdown_pin,
    input wire logic standby_pin,
    input wire logic rateChange,
    input wire logic [NCH-1:0] filtOutP,
    input wire logic [NCH-1:0] filtOutN,
    input wire logic [SAMPLE_W-1:0] rawSample,
    input wire logic [SAMPLE_W-1:0] corrTerm,
    output logic gp_out_a,
    output logic gp_out_b,
    output logic tuneActive,
    output logic [1:0] hpRatioSel,
    output logic [4:0] lpfScale,
    output logic [7:0] lnaBias,
    output logic dcsEnable,
    output logic sampleValid,
    output logic refOn,
    output logic pllBiasOn,
    output logic lvdsData,
    output logic lvdsFrame,
    output logic lvdsOe,
    output logic [SAMPLE_W-1:0] adcResult
);
    // Registers
    logic [7:0] tuneHp_ff;
    logic [7:0] route_ff;
    logic [7:0] lpf_ff;
    logic [7:0] lna_ff;
    logic [7:0] clkCtrl_ff;
    logic [7:0] rdata_ff;
    logic [9:0] tuneCnt_ff;
    logic tuneAct_ff;
    logic [3:0] dllCnt_ff;
    logic sValid_ff;
    aftpc_pwr_t pwr_ff;
    logic [$clog2(WAKE_MAX+1)-1:0] wake_ff;
    logic [$clog2(WAKE_MAX+1)-1:0] pdTime_ff;
    logic gpA_ff, gpB_ff;
    logic refOn_ff, pllOn_ff, oe_ff, dat_ff, frm_ff;
    logic [SAMPLE_W-1:0] res_ff;
    logic dcsPhase_ff;

    // Address decode
    wire hitTune = regReq.addr == REG_FILT_TUNE_HP;
    wire hitRoute = regReq.addr == REG_FILT_ROUTE;
    wire hitLpf = regReq.addr == REG_LPF_SCALE;
    wire hitLna = regReq.addr == REG_LNA_BIAS;
    wire hitClk = regReq.addr == REG_CLK_CTRL;
    wire hitStat = regReq.addr == REG_STATUS;
    wire wrTune = regReq.wrEn && hitTune;
    wire tuneStart = wrTune && regReq.wdata[TUNE_START_BIT];
    wire tuneDone = tuneAct_ff && (tuneCnt_ff == 10'(TUNE_CYCLES - 1));
    wire clkWrChange = regReq.wrEn && hitClk;
    wire dllRestart = rateChange || clkWrChange;

    // Read mux; status shows tuning, lock and power state
    wire [7:0] statusVal = {4'h0, pwr_ff, sValid_ff, tuneAct_ff};
    wire [7:0] nxt_rdata = hitTune ? {tuneHp_ff[7], tuneAct_ff, tuneHp_ff[5:0]} :
                           hitRoute ? route_ff :
                           hitLpf ? lpf_ff :
                           hitLna ? lna_ff :
                           hitClk ? clkCtrl_ff :
                           hitStat ? statusVal : 8'h00;

    // Test route channel select held in bits 2:0 of the route register
    wire [2:0] chSel = route_ff[2:0];
    wire routeOn = route_ff[ROUTE_EN_BIT];
    wire selP = filtOutP[chSel];
    wire selN = filtOutN[chSel];
    wire inLowPower = (pwr_ff == AFTPC_POWERDOWN_PIN) || (pwr_ff == AFTPC_STANDBY_PIN);

    // Register writes
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tuneHp_ff <= RST_FILT_TUNE_HP;
            route_ff <= RST_FILT_ROUTE;
            lpf_ff <= RST_LPF_SCALE;
            lna_ff <= RST_LNA_BIAS;
            clkCtrl_ff <= RST_CLK_CTRL;
            rdata_ff <= 8'h00;
        end else if (clkEn) begin
            if (wrTune) tuneHp_ff <= regReq.wdata;
            if (regReq.wrEn && hitRoute) route_ff <= regReq.wdata;
            if (regReq.wrEn && hitLpf) lpf_ff <= regReq.wdata;
            if (regReq.wrEn && hitLna) lna_ff <= regReq.wdata;
            if (clkWrChange) clkCtrl_ff <= regReq.wdata;
            if (regReq.rdEn) rdata_ff <= nxt_rdata;
        end
    end

    // Tuning sequencer: fixed 512-cycle run, start bit self-clears
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tuneAct_ff <= 1'b0;
            tuneCnt_ff <= '0;
        end else if (clkEn) begin
            if (tuneStart && !tuneAct_ff) begin
                tuneAct_ff <= 1'b1;
                tuneCnt_ff <= '0;
            end else if (tuneDone) begin
                tuneAct_ff <= 1'b0;
            end else if (tuneAct_ff) begin
                tuneCnt_ff <= tuneCnt_ff + 10'h001;
            end
        end
    end

    // Stabilizer lock window after a rate change
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dllCnt_ff <= '0;
            sValid_ff <= 1'b0;
            dcsPhase_ff <= 1'b0;
        end else if (clkEn) begin
            dcsPhase_ff <= clkCtrl_ff[DCS_EN_BIT] ? ~dcsPhase_ff : 1'b0;
            if (dllRestart || inLowPower) begin
                dllCnt_ff <= '0;
                sValid_ff <= 1'b0;
            end else if (dllCnt_ff != 4'(DLL_LOCK_CYCLES)) begin
                dllCnt_ff <= dllCnt_ff + 4'h1;
                sValid_ff <= 1'b0;
            end else begin
                sValid_ff <= 1'b1;
            end
        end
    end

    // Power state machine; power-down takes precedence over standby
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pwr_ff <= AFTPC_RUN;
            wake_ff <= '0;
            pdTime_ff <= '0;
        end else if (clkEn) begin
            unique case (pwr_ff)
                AFTPC_RUN: begin
                    pdTime_ff <= '0;
                    if (powerdown_pin) pwr_ff <= AFTPC_POWERDOWN_PIN;
                    else if (standby_pin) pwr_ff <= AFTPC_STANDBY_PIN;
                end
                AFTPC_POWERDOWN_PIN: begin
                    if (pdTime_ff != ($bits(pdTime_ff))'(WAKE_MAX)) begin
                        pdTime_ff <= pdTime_ff + 1'b1;
                    end
                    if (!powerdown_pin) begin
                        pwr_ff <= AFTPC_WAKE;
                        wake_ff <= pdTime_ff;
                    end
                end
                AFTPC_STANDBY_PIN: begin
                    if (powerdown_pin) begin
                        pwr_ff <= AFTPC_POWERDOWN_PIN;
                    end else if (!standby_pin) begin
                        pwr_ff <= AFTPC_WAKE;
                        wake_ff <= ($bits(wake_ff))'(STANDBY_PIN_WAKE_CYCLES);
                    end
                end
                AFTPC_WAKE: begin
                    if (powerdown_pin) begin
                        pwr_ff <= AFTPC_POWERDOWN_PIN;
                    end else if (standby_pin) begin
                        pwr_ff <= AFTPC_STANDBY_PIN;
                    end else if (wake_ff == '0) begin
                        pwr_ff <= AFTPC_RUN;
                    end else begin
                        wake_ff <= wake_ff - 1'b1;
                    end
                end
            endcase
        end
    end

    // ADC pipeline and serializer
    logic [SAMPLE_W-1:0] pipeOut;
    logic serBit, serFrame;
    aftpc_adc_pipe #(.WIDTH(SAMPLE_W), .DEPTH(PIPE_LATENCY)) u_pipe (
        .core_clk(core_clk),
        .srst(srst),
        .clkEn(clkEn),
        .rawSample(rawSample),
        .corrTerm(corrTerm),
        .result(pipeOut)
    );
    aftpc_serializer #(.WIDTH(SAMPLE_W)) u_ser (
        .core_clk(core_clk),
        .srst(srst),
        .clkEn(clkEn),
        .word(pipeOut),
        .serBit(serBit),
        .frameMark(serFrame)
    );

    // Registered outputs: test route, power enables, LVDS drivers; drivers and PLL stay off until wake-up ends
    always_ff @(posedge core_clk) begin
        if (srst) begin
            gpA_ff <= 1'b0;
            gpB_ff <= 1'b0;
            refOn_ff <= 1'b1;
            pllOn_ff <= 1'b1;
            oe_ff <= 1'b0;
            dat_ff <= 1'b0;
            frm_ff <= 1'b0;
            res_ff <= '0;
        end else if (clkEn) begin
            gpA_ff <= routeOn & selP;
            gpB_ff <= routeOn & selN;
            refOn_ff <= pwr_ff != AFTPC_POWERDOWN_PIN;
            pllOn_ff <= pwr_ff == AFTPC_RUN;
            oe_ff <= pwr_ff == AFTPC_RUN;
            dat_ff <= serBit;
            frm_ff <= serFrame;
            res_ff <= pipeOut;
        end
    end

    assign regRdata = rdata_ff;
    assign gp_out_a = gpA_ff;
    assign gp_out_b = gpB_ff;
    assign tuneActive = tuneAct_ff;
    assign hpRatioSel = tuneHp_ff[1:0];
    assign lpfScale = lpf_ff[7:3];
    assign lnaBias = lna_ff;
    assign dcsEnable = clkCtrl_ff[DCS_EN_BIT];
    assign sampleValid = sValid_ff;
    assign refOn = refOn_ff;
    assign pllBiasOn = pllOn_ff;
    assign lvdsData = dat_ff;
    assign lvdsFrame = frm_ff;
    assign lvdsOe = oe_ff;
    assign adcResult = res_ff;
endmodule

// ---- aftpc_checker.sv ----
module aftpc_checker
    import aftpc_pkg::*;
#(
    parameter int NCH = 8,
    parameter int WAKE_MAX = POWERDOWN_PIN_WAKE_CYCLES
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire aftpc_regreq_t regReq,
    input wire logic [7:0] regRdata,
    input wire logic powerdown_pin,
    input wire logic standby_pin,
    input wire logic rateChange,
    input wire logic [NCH-1:0] filtOutP,
    input wire logic [NCH-1:0] filtOutN,
    input wire logic gp_out_a,
    input wire logic gp_out_b,
    input wire logic tuneActive,
    input wire logic [1:0] hpRatioSel,
    input wire logic [7:0] lnaBias,
    input wire logic dcsEnable,
    input wire logic sampleValid,
    input wire logic refOn,
    input wire logic pllBiasOn,
    input wire logic lvdsOe
);
    int tnCnt_ff;
    int wkCnt_ff;
    logic [7:0] rtCtl_ff;
    logic wrTune, wrRoute, rdTune, rtA, rtB;
    logic [1:0] wHp;
    // Register strobes and expected route values
    assign wrTune = regReq.wrEn && clkEn && regReq.addr == REG_FILT_TUNE_HP;
    assign wrRoute = regReq.wrEn && clkEn && regReq.addr == REG_FILT_ROUTE;
    assign rdTune = regReq.rdEn && clkEn && regReq.addr == REG_FILT_TUNE_HP;
    assign wHp = regReq.wdata[1:0];
    assign rtA = rtCtl_ff[ROUTE_EN_BIT] & filtOutP[rtCtl_ff[2:0]];
    assign rtB = rtCtl_ff[ROUTE_EN_BIT] & filtOutN[rtCtl_ff[2:0]];
    // Run length, wake length, route shadow
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tnCnt_ff <= 0;
            wkCnt_ff <= 0;
            rtCtl_ff <= 8'h00;
        end else begin
            tnCnt_ff <= tuneActive ? tnCnt_ff + 1 : 0;
            wkCnt_ff <= (!lvdsOe && !powerdown_pin && !standby_pin) ? wkCnt_ff + 1 : 0;
            rtCtl_ff <= wrRoute ? regReq.wdata : rtCtl_ff;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_tuneGo;
        wrTune && regReq.wdata[TUNE_START_BIT] && !tuneActive;
    endsequence
    sequence s_rdStable;
        rdTune ##1 $stable(tuneActive);
    endsequence
    property p_tuneLen;
        (tnCnt_ff <= TUNE_CYCLES) and ($fell(tuneActive) && !$past(srst) |-> tnCnt_ff == TUNE_CYCLES);
    endproperty
    property p_tuneGo;
        s_tuneGo |=> tuneActive;
    endproperty
    property p_hpSel;
        wrTune |=> hpRatioSel == $past(wHp);
    endproperty
    property p_tuneBit;
        s_rdStable |=> regRdata[TUNE_START_BIT] == $past(tuneActive);
    endproperty
    property p_route;
        lvdsOe && $past(lvdsOe) |-> gp_out_a == $past(rtA) && gp_out_b == $past(rtB);
    endproperty
    property p_pdOff;
        powerdown_pin [*3] |-> !lvdsOe && !refOn && !pllBiasOn;
    endproperty
    property p_sbOff;
        (standby_pin && !powerdown_pin) [*3] |-> !lvdsOe && !pllBiasOn && refOn;
    endproperty
    property p_wake;
        wkCnt_ff <= WAKE_MAX + 3;
    endproperty
    property p_rstVal;
        $fell(srst) |-> lnaBias == RST_LNA_BIAS && dcsEnable;
    endproperty
    property p_lock;
        rateChange |=> (!sampleValid) [*8];
    endproperty
    a_tuneLen: assert property (p_tuneLen) else $error("tuning run length wrong");
    a_tuneGo: assert property (p_tuneGo) else $error("tuning did not start");
    a_hpSel: assert property (p_hpSel) else $error("ratio select not updated");
    a_tuneBit: assert property (p_tuneBit) else $error("start bit does not follow run");
    a_route: assert property (p_route) else $error("test route output wrong");
    a_pdOff: assert property (p_pdOff) else $error("power-down outputs wrong");
    a_sbOff: assert property (p_sbOff) else $error("standby outputs wrong");
    a_wake: assert property (p_wake) else $error("wake-up too long");
    a_rstVal: assert property (p_rstVal) else $error("bias or stabilizer reset wrong");
    a_lock: assert property (p_lock) else $error("samples valid during relock");
endmodule

bind aftpc_core aftpc_checker #(.NCH(NCH), .WAKE_MAX(WAKE_MAX)) i_chk (.*);

// ---- aftpc_host_model.sv ----
module aftpc_host_model
    import aftpc_pkg::*;
(
    input wire logic core_clk,
    output aftpc_regreq_t regReq,
    output logic powerdown_pin,
    output logic standby_pin,
    output logic rateChange
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus and pins at time zero
    initial begin
        regReq = '0;
        powerdown_pin = 1'b0;
        standby_pin = 1'b0;
        rateChange = 1'b0;
    end
    // One access, released with scrambled address and data
    task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regReq <= '{wrEn: w, rdEn: !w, addr: a, wdata: d};
        @(posedge core_clk);
        regReq <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [9:0] a);
        xfer(1'b0, a, 8'hA5);
    endtask
    // Retune after power-up or cutoff change
    task automatic tune(input logic [1:0] hp);
        wr(REG_FILT_TUNE_HP, {6'h10, hp});
    endtask
    task automatic pins(input logic pd, input logic sb);
        @(posedge core_clk);
        powerdown_pin <= pd;
        standby_pin <= sb;
    endtask
    // Rate change; caller ignores samples for a while
    task automatic pulseRate();
        @(posedge core_clk);
        rateChange <= 1'b1;
        @(posedge core_clk);
        rateChange <= 1'b0;
    endtask
endmodule

// ---- tb_top.sv ----
module tb_top
    import aftpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WAKE_SIM = 80;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic clkEn = 1'b1;
    aftpc_regreq_t regReq;
    logic powerdown_pin, standby_pin, rateChange, gp_out_a, gp_out_b, tuneActive, dcsEnable;
    logic sampleValid, refOn, pllBiasOn, lvdsData, lvdsFrame, lvdsOe;
    logic [7:0] filtOutP = 8'h00;
    logic [7:0] filtOutN = 8'h00;
    logic [SAMPLE_W-1:0] rawSample = '0;
    logic [SAMPLE_W-1:0] corrTerm = '0;
    logic [SAMPLE_W-1:0] adcResult;
    logic [7:0] regRdata, lnaBias;
    logic [1:0] hpRatioSel, gpExp;
    logic [4:0] lpfScale;
    logic [31:0] seed = 32'h0000DC8B;
    logic [7:0] expQ[$];
    logic [SAMPLE_W-1:0] resQ[$];
    int frmGap = 0;
    logic rdF1 = 1'b0;
    logic rdF2 = 1'b0;
    int error_cnt = 0;
    int samples_checked = 0;
    int n, w5, w100, w150, wsb;

    aftpc_host_model i_host (.*);
    aftpc_core #(.NCH(8), .WAKE_MAX(WAKE_SIM)) i_dut (.*);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdChk(input logic [9:0] a, input logic [7:0] e);
        expQ.push_back(e);
        i_host.rd(a);
    endtask
    // Hold a low-power pin, then count wake cycles
    task automatic lowPow(input logic pd, input int d, output int w);
        i_host.pins(pd, !pd);
        repeat (d) @(posedge core_clk);
        @(negedge core_clk);
        check(16'({lvdsOe, refOn, pllBiasOn}), 16'({1'b0, !pd, 1'b0}));
        i_host.pins(1'b0, 1'b0);
        w = 0;
        while (lvdsOe !== 1'b1 && w < 400) begin
            @(negedge core_clk);
            w++;
        end
    endtask
    task automatic results();
        $display("Mismatches %0d, comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        forever #20 core_clk = ~core_clk;
    end
    // Random filter and sample inputs
    always @(posedge core_clk) begin
        if (!srst) resQ.push_back(SAMPLE_W'(rawSample + corrTerm));
        filtOutP <= 8'(rnd());
        filtOutN <= 8'(rnd());
        rawSample <= SAMPLE_W'(rnd());
        corrTerm <= SAMPLE_W'(rnd());
    end
    // Read answers compared in issue order
    always @(posedge core_clk) begin
        rdF1 <= regReq.rdEn;
        rdF2 <= rdF1;
    end
    always @(negedge core_clk) begin
        if (rdF2) begin
            check(16'(regRdata), 16'(expQ.pop_front()));
        end
    end
    // Pipeline result after fixed latency, frame mark period
    always @(negedge core_clk) begin
        if (resQ.size() > PIPE_LATENCY) begin
            check(16'(adcResult), 16'(resQ.pop_front()));
        end
        if (lvdsFrame === 1'b1) begin
            if (frmGap != 0) check(16'(frmGap), 16'h000E);
            frmGap = 1;
        end else if (frmGap != 0) begin
            frmGap++;
        end
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        results();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        rdChk(REG_LNA_BIAS, RST_LNA_BIAS);
        rdChk(REG_CLK_CTRL, RST_CLK_CTRL);
        rdChk(REG_FILT_TUNE_HP, RST_FILT_TUNE_HP);
        i_host.wr(10'h3FF, 8'hFF);
        rdChk(10'h3FF, 8'h00);
        i_host.wr(REG_CLK_CTRL, 8'h00);
        @(negedge core_clk);
        check(16'(dcsEnable), 16'h0000);
        for (int k = 0; k < 4; k++) begin
            i_host.wr(REG_FILT_TUNE_HP, 8'(k));
            @(negedge core_clk);
            check(16'(hpRatioSel), 16'(k));
            rdChk(REG_FILT_TUNE_HP, 8'(k));
        end
        n = int'(rnd());
        i_host.wr(REG_LPF_SCALE, 8'(n));
        @(negedge core_clk);
        check(16'(lpfScale), 16'(n[7:3]));
        for (int k = 0; k < 4; k++) begin
            n = int'(rnd() & 32'h7);
            i_host.wr(REG_FILT_ROUTE, k < 3 ? 8'(n) | 8'h10 : 8'(n));
            repeat (2) @(posedge core_clk);
            gpExp = k < 3 ? {filtOutP[n], filtOutN[n]} : 2'b00;
            @(negedge core_clk);
            check(16'({gp_out_a, gp_out_b}), 16'(gpExp));
        end
        i_host.tune(2'b11);
        fork
            begin
                repeat (100) @(posedge core_clk);
                i_host.wr(REG_FILT_TUNE_HP, 8'h43);
                rdChk(REG_FILT_TUNE_HP, 8'h43);
            end
        join_none
        n = 0;
        @(negedge core_clk);
        while (tuneActive === 1'b1 && n < 600) begin
            n++;
            @(negedge core_clk);
        end
        check(16'(n), 16'(TUNE_CYCLES));
        rdChk(REG_FILT_TUNE_HP, 8'h03);
        i_host.pulseRate();
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        check(16'(sampleValid), 16'h0001);
        lowPow(1'b1, 5, w5);
        lowPow(1'b1, 100, w100);
        lowPow(1'b1, 150, w150);
        lowPow(1'b0, 10, wsb);
        check(16'(w5 < w100), 16'h0001);
        check(16'(w100), 16'(w150));
        check(16'(w100 <= WAKE_SIM + 4), 16'h0001);
        check(16'(wsb < w100), 16'h0001);
        results();
    end
endmodule
